// >>> rtl/pfci_pkg.sv
// shared constants and types of the pause frame control interface
package pfci_pkg;
  localparam int unsigned PFCI_NPRIO = 9;
  localparam int unsigned PFCI_GLOBAL = 8;
  localparam int unsigned PFCI_NEVT = 5;
  // apb byte offsets
  localparam logic [7:0] PFCI_CTRL_OFF = 8'h00;
  localparam logic [7:0] PFCI_RXEN_OFF = 8'h04;
  localparam logic [7:0] PFCI_STA_LO_OFF = 8'h08;
  localparam logic [7:0] PFCI_STA_HI_OFF = 8'h0c;
  localparam logic [7:0] PFCI_PEER_LO_OFF = 8'h10;
  localparam logic [7:0] PFCI_PEER_HI_OFF = 8'h14;
  localparam logic [7:0] PFCI_STATUS_OFF = 8'h18;
  localparam logic [7:0] PFCI_MASK_OFF = 8'h1c;
  localparam logic [7:0] PFCI_REQ_OFF = 8'h20;
  // event bit positions in status and mask
  localparam int unsigned PFCI_EV_GCP = 0;
  localparam int unsigned PFCI_EV_PCP = 1;
  localparam int unsigned PFCI_EV_GPP = 2;
  localparam int unsigned PFCI_EV_PPP = 3;
  localparam int unsigned PFCI_EV_REJ = 4;
  // reset values
  localparam logic [23:0] PFCI_CTRL_RST = 24'h00_0000;
  localparam logic [8:0] PFCI_RXEN_RST = 9'h1ff;
  localparam logic [47:0] PFCI_ADDR_RST = 48'h0000_0000_0000;
  localparam logic [4:0] PFCI_MASK_RST = 5'h00;
  // frame field values
  localparam logic [47:0] PFCI_FLOW_MCAST = 48'h0180_c200_0001;
  localparam logic [15:0] PFCI_ETYPE = 16'h8808;
  localparam logic [15:0] PFCI_OP_GLOBAL = 16'h0001;
  localparam logic [15:0] PFCI_OP_PRIO = 16'h0101;

  typedef enum logic [1:0] {
    PFCI_APB_IDLE = 2'b00,
    PFCI_APB_DONE = 2'b01
  } pfci_apb_type;

  // one frame class: bit 0 enable, bits 1..5 checks
  typedef struct packed {
    logic opcode_check;
    logic ethertype_check;
    logic srcaddr_check;
    logic ucast_check;
    logic mcast_check;
    logic class_en;
  } pfci_class_type;

  // index 0 global control, 1 priority control, 2 global flow, 3 priority flow
  typedef pfci_class_type [3:0] pfci_cfg_type;

  // parsed header of a received mac control frame
  typedef struct packed {
    logic valid;
    logic good;
    logic [47:0] dest;
    logic [47:0] src;
    logic [15:0] ethertype;
    logic [15:0] opcode;
    logic [7:0] prio_vec;
    logic [7:0][15:0] quanta;
  } pfci_frame_type;
endpackage

// >>> rtl/pfci_top.sv
// pause frame control interface: rx classification, flow handshake, apb registers
//
// Contract
// [RQ1] rx priority enable gates only user outputs
// [RQ2] tx priority enable permits pause transmission
// [RQ3] global control class only while enabled
// [RQ4] priority control class only while enabled
// [RQ5] global flow class only while enabled
// [RQ6] priority flow class only while enabled
// [RQ7] multicast address checked only when selected
// [RQ8] unicast address checked only when selected
// [RQ9] source address checked only when selected
// [RQ10] ethertype checked only when selected
// [RQ11] opcode checked only when selected
// [RQ12] request bit set, held until processed
// [RQ13] user acknowledges each request bit
// [RQ14] valid marks fresh quanta, global on 8
// [RQ15] user applies flagged quanta
// [RQ16] eight priority quanta outputs of 16 bits
// [RQ17] global quanta lands on index 8
// [RQ18] acknowledge clears request for reuse
// [RQ19] rx side on rx clock, tx resynchronised
module pfci_top
  import pfci_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire pfci_frame_type rx_frame,
  input wire logic [8:0] rx_flow_acknowledge,
  output logic [8:0] rx_flow_request,
  output logic [8:0] rx_flow_valid,
  output logic [8:0][15:0] rx_flow_quanta,
  input wire logic [8:0] tx_flow_prio_enable,
  output logic [8:0] tx_flow_gate,
  output logic irq
);

  typedef struct packed {
    pfci_apb_type apb;
    logic ready;
    logic slverr;
    logic [31:0] rdata;
    pfci_cfg_type cfg;
    logic [8:0] rx_en;
    logic [47:0] station;
    logic [47:0] peer;
    logic [4:0] status;
    logic [4:0] mask;
    logic irq;
    logic [8:0] req;
    logic [8:0] valid;
    logic [8:0][15:0] quanta;
    logic [8:0] tx_s1;
    logic [8:0] tx_s2;
  } pfci_state_type;

  pfci_state_type s;
  pfci_state_type next_s;

  // one class accepts a good frame when enabled, one selected address check matches and every other selected check passes
  function automatic logic class_pass(
    input pfci_class_type c,
    input pfci_frame_type f,
    input logic [47:0] station,
    input logic [47:0] peer,
    input logic [15:0] op
  );
    logic da_ok;
    logic sa_ok;
    logic et_ok;
    logic op_ok;
    // with neither address check selected any destination is taken
    da_ok = !(c.mcast_check || c.ucast_check) ||
            (c.mcast_check && f.dest == PFCI_FLOW_MCAST) || // [RQ7]
            (c.ucast_check && f.dest == station); // [RQ8]
    sa_ok = !c.srcaddr_check || f.src == peer; // [RQ9]
    et_ok = !c.ethertype_check || f.ethertype == PFCI_ETYPE; // [RQ10]
    op_ok = !c.opcode_check || f.opcode == op; // [RQ11]
    return c.class_en && f.valid && f.good && da_ok && sa_ok && et_ok && op_ok;
  endfunction

  logic prio_grp;
  logic gcp_hit;
  logic pcp_hit;
  logic gpp_hit;
  logic ppp_hit;
  logic [8:0] flow_hit;
  logic [8:0] flow_set;
  logic [4:0] events;
  logic [4:0] clr;
  logic apb_wr;

  always_comb begin
    // the opcode picks the group; with opcode checks off, the global
    // group takes every frame that is not priority based
    prio_grp = rx_frame.opcode == PFCI_OP_PRIO;
    gpp_hit = !prio_grp &&
              class_pass(s.cfg[2], rx_frame, s.station, s.peer, PFCI_OP_GLOBAL); // [RQ5]
    gcp_hit = !prio_grp && !gpp_hit &&
              class_pass(s.cfg[0], rx_frame, s.station, s.peer, PFCI_OP_GLOBAL); // [RQ3]
    ppp_hit = prio_grp &&
              class_pass(s.cfg[3], rx_frame, s.station, s.peer, PFCI_OP_PRIO); // [RQ6]
    pcp_hit = prio_grp && !ppp_hit &&
              class_pass(s.cfg[1], rx_frame, s.station, s.peer, PFCI_OP_PRIO); // [RQ4]
    flow_hit = {gpp_hit, ppp_hit ? rx_frame.prio_vec : 8'h00};
    // internal processing sees every hit; the enable masks only the outputs
    flow_set = flow_hit & s.rx_en; // [RQ1]
    events = '0;
    events[PFCI_EV_GCP] = gcp_hit;
    events[PFCI_EV_PCP] = pcp_hit;
    events[PFCI_EV_GPP] = gpp_hit;
    events[PFCI_EV_PPP] = ppp_hit;
    events[PFCI_EV_REJ] = rx_frame.valid && !(gcp_hit || pcp_hit || gpp_hit || ppp_hit);

    next_s = s;
    // writes land on the edge where the master sees pready high
    apb_wr = psel && penable && pwrite && s.ready;
    clr = '0;
    case (s.apb)
      PFCI_APB_IDLE: begin
        if (psel && penable) begin
          next_s.apb = PFCI_APB_DONE;
          next_s.ready = 1'b1;
          next_s.slverr = 1'b0;
          next_s.rdata = '0;
          case (paddr)
            PFCI_CTRL_OFF: next_s.rdata[23:0] = s.cfg;
            PFCI_RXEN_OFF: next_s.rdata[8:0] = s.rx_en;
            PFCI_STA_LO_OFF: next_s.rdata = s.station[31:0];
            PFCI_STA_HI_OFF: next_s.rdata[15:0] = s.station[47:32];
            PFCI_PEER_LO_OFF: next_s.rdata = s.peer[31:0];
            PFCI_PEER_HI_OFF: next_s.rdata[15:0] = s.peer[47:32];
            PFCI_STATUS_OFF: next_s.rdata[4:0] = s.status;
            PFCI_MASK_OFF: next_s.rdata[4:0] = s.mask;
            PFCI_REQ_OFF: next_s.rdata[24:0] = {s.tx_s2, 7'h00, s.req};
            default: next_s.slverr = 1'b1;
          endcase
        end
      end
      PFCI_APB_DONE: begin
        next_s.apb = PFCI_APB_IDLE;
        next_s.ready = 1'b0;
        next_s.slverr = 1'b0;
        if (apb_wr) begin
          case (paddr)
            PFCI_CTRL_OFF: next_s.cfg = pwdata[23:0];
            PFCI_RXEN_OFF: next_s.rx_en = pwdata[8:0];
            PFCI_STA_LO_OFF: next_s.station[31:0] = pwdata;
            PFCI_STA_HI_OFF: next_s.station[47:32] = pwdata[15:0];
            PFCI_PEER_LO_OFF: next_s.peer[31:0] = pwdata;
            PFCI_PEER_HI_OFF: next_s.peer[47:32] = pwdata[15:0];
            PFCI_STATUS_OFF: clr = pwdata[4:0];
            PFCI_MASK_OFF: next_s.mask = pwdata[4:0];
            default: clr = '0;
          endcase
        end
      end
      default: begin
        next_s.apb = PFCI_APB_IDLE;
        next_s.ready = 1'b0;
      end
    endcase

    // a new event in the clearing cycle survives
    next_s.status = (s.status & ~clr) | events;
    next_s.irq = |(next_s.status & next_s.mask);

    // ack clears, a fresh frame in the same cycle sets again
    next_s.req = (s.req & ~rx_flow_acknowledge) | flow_set; // [RQ12] [RQ18]
    next_s.valid = flow_set; // [RQ14]
    for (int i = 0; i < PFCI_NPRIO; i++) begin
      if (flow_set[i]) begin
        // global pause carries its single quanta in the first slot
        next_s.quanta[i] = (i == PFCI_GLOBAL) ? rx_frame.quanta[0] : // [RQ17]
                           rx_frame.quanta[i[2:0]]; // [RQ16]
      end
    end

    // tx enable arrives from the transmit side: two flops before use
    next_s.tx_s1 = tx_flow_prio_enable; // [RQ19]
    next_s.tx_s2 = s.tx_s1; // [RQ2]
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      s <= '0;
      s.apb <= PFCI_APB_IDLE;
      s.cfg <= PFCI_CTRL_RST;
      s.rx_en <= PFCI_RXEN_RST;
      s.station <= PFCI_ADDR_RST;
      s.peer <= PFCI_ADDR_RST;
      s.mask <= PFCI_MASK_RST;
    end else begin
      s <= next_s;
    end
  end

  assign prdata = s.rdata;
  assign pready = s.ready;
  assign pslverr = s.slverr;
  assign rx_flow_request = s.req;
  assign rx_flow_valid = s.valid;
  assign rx_flow_quanta = s.quanta;
  assign tx_flow_gate = s.tx_s2;
  assign irq = s.irq;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rstn);

  sequence flow_raise;
    rx_frame.valid && (flow_set != 9'h000);
  endsequence

  sequence flow_shown;
    rx_flow_valid == $past(flow_set) && (rx_flow_request & $past(flow_set)) == $past(flow_set);
  endsequence

  a_rx_enable_gate: assert property ( // [RQ1]
    ((rx_flow_request & ~$past(rx_flow_request)) & ~$past(s.rx_en)) == 9'h000
  ) else $error("request raised for disabled priority");

  a_tx_gate_sync: assert property ( // [RQ2]
    $past(rstn, 2) |-> tx_flow_gate == $past(tx_flow_prio_enable, 2)
  ) else $error("tx gate not two cycles behind enable");

  a_gcp_class_off: assert property ( // [RQ3]
    !s.cfg[0].class_en && !s.status[PFCI_EV_GCP] |=> !s.status[PFCI_EV_GCP]
  ) else $error("global control seen while disabled");

  a_pcp_class_off: assert property ( // [RQ4]
    !s.cfg[1].class_en && !s.status[PFCI_EV_PCP] |=> !s.status[PFCI_EV_PCP]
  ) else $error("priority control seen while disabled");

  a_gpp_class_off: assert property ( // [RQ5]
    !s.cfg[2].class_en |=> !rx_flow_valid[PFCI_GLOBAL]
  ) else $error("global pause seen while disabled");

  a_ppp_class_off: assert property ( // [RQ6]
    !s.cfg[3].class_en |=> rx_flow_valid[7:0] == 8'h00
  ) else $error("priority pause seen while disabled");

  a_sa_mismatch: assert property ( // [RQ9]
    s.cfg[3].srcaddr_check && rx_frame.src != s.peer |=> rx_flow_valid[7:0] == 8'h00
  ) else $error("priority pause taken with foreign source");

  a_req_hold: assert property ( // [RQ12]
    ((($past(rx_flow_request) & ~$past(rx_flow_acknowledge)) & ~rx_flow_request) == 9'h000)
  ) else $error("request dropped without acknowledge");

  a_flow_report: assert property ( // [RQ14]
    flow_raise |=> flow_shown
  ) else $error("pause frame not reported next cycle");

  a_prio_quanta: assert property ( // [RQ16]
    flow_set[0] |=> rx_flow_quanta[0] == $past(rx_frame.quanta[0])
  ) else $error("priority 0 quanta not captured");

  a_global_quanta: assert property ( // [RQ17]
    flow_set[PFCI_GLOBAL] |=> rx_flow_valid[PFCI_GLOBAL] &&
      rx_flow_quanta[PFCI_GLOBAL] == $past(rx_frame.quanta[0])
  ) else $error("global quanta not on index 8");

  a_ack_clears: assert property ( // [RQ18]
    (rx_flow_request & rx_flow_acknowledge & ~flow_set) != 9'h000 |=>
      (rx_flow_request & $past(rx_flow_acknowledge & ~flow_set)) == 9'h000
  ) else $error("acknowledged request still set");

  a_irq_level: assert property (
    irq == |(s.status & s.mask)
  ) else $error("interrupt does not follow status and mask");

  // a global pause frame that fails one selected check must leave valid[8] low
  sequence global_dropped;
    !rx_flow_valid[PFCI_GLOBAL];
  endsequence

  sequence mcast_miss;
    rx_frame.valid && !prio_grp && s.cfg[2].mcast_check && !s.cfg[2].ucast_check &&
      rx_frame.dest != PFCI_FLOW_MCAST;
  endsequence

  sequence ucast_miss;
    rx_frame.valid && !prio_grp && s.cfg[2].ucast_check && !s.cfg[2].mcast_check &&
      rx_frame.dest != s.station;
  endsequence

  sequence etype_miss;
    rx_frame.valid && s.cfg[2].ethertype_check && rx_frame.ethertype != PFCI_ETYPE;
  endsequence

  sequence opcode_miss;
    rx_frame.valid && s.cfg[2].opcode_check && rx_frame.opcode != PFCI_OP_GLOBAL;
  endsequence

  a_mcast_check: assert property ( // [RQ7]
    mcast_miss |=> global_dropped
  ) else $error("global pause taken with foreign multicast address");

  a_ucast_check: assert property ( // [RQ8]
    ucast_miss |=> global_dropped
  ) else $error("global pause taken with foreign unicast address");

  a_etype_check: assert property ( // [RQ10]
    etype_miss |=> global_dropped
  ) else $error("global pause taken with wrong ethertype");

  a_opcode_check: assert property ( // [RQ11]
    opcode_miss |=> global_dropped
  ) else $error("global pause taken with wrong opcode");

  a_ppp_internal: assert property ( // [RQ1]
    ppp_hit |=> s.status[PFCI_EV_PPP]
  ) else $error("priority pause not processed internally");

  a_gcp_event: assert property ( // [RQ3]
    gcp_hit |=> s.status[PFCI_EV_GCP]
  ) else $error("global control hit not recorded");

  a_pcp_event: assert property ( // [RQ4]
    pcp_hit |=> s.status[PFCI_EV_PCP]
  ) else $error("priority control hit not recorded");

  a_reject_event: assert property (
    rx_frame.valid && !(gcp_hit || pcp_hit || gpp_hit || ppp_hit) |=> s.status[PFCI_EV_REJ]
  ) else $error("rejected frame not recorded");

  a_valid_source: assert property ( // [RQ14]
    rx_flow_valid != 9'h000 |-> $past(rx_frame.valid)
  ) else $error("pause valid without a received frame");

  a_status_sticky: assert property (
    (($past(s.status) & ~$past(clr)) & ~s.status) == 5'h00
  ) else $error("status bit lost without a clear");

  a_answer_pulse: assert property (
    pready |=> !pready
  ) else $error("bus answer longer than one cycle");

  a_error_with_ready: assert property (
    pslverr |-> pready
  ) else $error("bus error without answer");

  a_quanta_hold: assert property ( // [RQ16]
    !flow_set[1] |=> $stable(rx_flow_quanta[1])
  ) else $error("priority 1 quanta changed without a frame");

endmodule

// >>> testbench/pfci_top_bench.sv
// self-checking bench of the pause frame control interface
module pfci_top_bench
  import pfci_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk, rstn, psel, penable, pwrite, pready, pslverr, irq, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  pfci_frame_type rx_frame;
  logic [8:0] ack, req, vld, tx_en, gate;
  logic [8:0][15:0] quanta, applied;
  logic [2:0] ack_delay;
  int num_errors = 0;
  int n_tests = 0;

`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin num_errors++; \
  $display("[ERR] %s expected %0h seen %0h", nm, e, g); end end

  pfci_top DUT (.sys_clk(sys_clk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rx_frame(rx_frame), .rx_flow_acknowledge(ack),
    .rx_flow_request(req), .rx_flow_valid(vld), .rx_flow_quanta(quanta),
    .tx_flow_prio_enable(tx_en), .tx_flow_gate(gate), .irq(irq));
  pfci_user_model USER (.sys_clk(sys_clk), .rstn(rstn), .ack_delay(ack_delay),
    .rx_flow_request(req), .rx_flow_valid(vld), .rx_flow_quanta(quanta),
    .rx_flow_acknowledge(ack), .applied(applied));

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  task automatic complete_run;
    $display("checks %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // starts one edge late so a release is never overwritten in the same step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    `CHK("apb answer", 1'b1, pready)
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string nm);
    apb(1'b0, a, 32'h0);
    `CHK(nm, e, rd)
  endtask

  // returns one edge after the edge that takes the frame
  task automatic frame(input logic [15:0] et, input logic [15:0] op, input logic [7:0] pv,
                       input logic [15:0] q0);
    pfci_frame_type f;
    f = '0;
    f.valid = 1'b1;
    f.good = 1'b1;
    f.dest = PFCI_FLOW_MCAST;
    f.ethertype = et;
    f.opcode = op;
    f.prio_vec = pv;
    for (int i = 0; i < 8; i++) begin
      f.quanta[i] = q0 + 16'(i);
    end
    @(posedge sys_clk);
    rx_frame <= f;
    @(posedge sys_clk);
    rx_frame.valid <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic s_reset;
    rdc(PFCI_RXEN_OFF, 32'h1ff, "rx enable reset");
    rdc(PFCI_CTRL_OFF, 32'h0, "class config reset");
    apb(1'b0, 8'h40, 32'h0);
    `CHK("unmapped error", 1'b1, err)
  endtask

  task automatic s_disabled;
    frame(PFCI_ETYPE, PFCI_OP_GLOBAL, 8'h00, 16'h1234);
    `CHK("disabled valid", 9'h000, vld)
    rdc(PFCI_STATUS_OFF, 32'h10, "reject status");
    apb(1'b1, PFCI_STATUS_OFF, 32'h1f);
  endtask

  task automatic s_global;
    int n;
    n = 0;
    ack_delay <= 3'h6;
    apb(1'b1, PFCI_CTRL_OFF, 32'h0001_1000);
    apb(1'b1, PFCI_MASK_OFF, 32'h4);
    frame(16'h8809, PFCI_OP_GLOBAL, 8'h00, 16'h1234);
    `CHK("bad ethertype valid", 9'h000, vld)
    `CHK("masked reject irq", 1'b0, irq)
    frame(PFCI_ETYPE, PFCI_OP_GLOBAL, 8'h00, 16'h1234);
    `CHK("global valid", 9'h100, vld)
    `CHK("global quanta", 16'h1234, quanta[8])
    `CHK("global request", 9'h100, req)
    `CHK("event irq", 1'b1, irq)
    repeat (3) @(posedge sys_clk);
    `CHK("request held", 1'b1, req[8])
    while (req[8] !== 1'b0 && n < 20) begin
      @(posedge sys_clk);
      n++;
    end
    `CHK("request cleared", 1'b0, req[8])
    `CHK("user quanta", 16'h1234, applied[8])
    apb(1'b1, PFCI_STATUS_OFF, 32'h1f);
    @(posedge sys_clk);
    `CHK("cleared irq", 1'b0, irq)
  endtask

  task automatic s_prio;
    ack_delay <= 3'h0;
    apb(1'b1, PFCI_CTRL_OFF, 32'h0004_0000);
    apb(1'b1, PFCI_RXEN_OFF, 32'h1fe);
    frame(PFCI_ETYPE, PFCI_OP_PRIO, 8'h81, 16'h2000);
    `CHK("prio valid", 9'h080, vld)
    `CHK("prio quanta", 16'h2007, quanta[7])
    `CHK("gated quanta", 16'h0000, quanta[0])
    rdc(PFCI_STATUS_OFF, 32'h8, "prio status");
    `CHK("prompt clear", 9'h000, req)
  endtask

  task automatic s_ctrl;
    apb(1'b1, PFCI_STATUS_OFF, 32'h1f);
    apb(1'b1, PFCI_CTRL_OFF, 32'h41);
    frame(PFCI_ETYPE, PFCI_OP_GLOBAL, 8'h00, 16'h0055);
    `CHK("control valid", 9'h000, vld)
    frame(PFCI_ETYPE, PFCI_OP_PRIO, 8'h01, 16'h0055);
    rdc(PFCI_STATUS_OFF, 32'h3, "control status");
  endtask

  task automatic s_checks;
    apb(1'b1, PFCI_PEER_LO_OFF, 32'h0000_00aa);
    rdc(PFCI_PEER_LO_OFF, 32'h0000_00aa, "peer low");
    apb(1'b1, PFCI_CTRL_OFF, 32'h0024_0000);
    frame(PFCI_ETYPE, PFCI_OP_PRIO, 8'h02, 16'h0300);
    `CHK("source mismatch valid", 9'h000, vld)
    apb(1'b1, PFCI_CTRL_OFF, 32'h0002_1000);
    frame(PFCI_ETYPE, 16'h0002, 8'h00, 16'h0400);
    `CHK("bad opcode valid", 9'h000, vld)
    frame(PFCI_ETYPE, PFCI_OP_GLOBAL, 8'h00, 16'h0401);
    `CHK("good opcode valid", 9'h100, vld)
    apb(1'b1, PFCI_CTRL_OFF, 32'h0000_3000);
    frame(PFCI_ETYPE, PFCI_OP_GLOBAL, 8'h00, 16'h0500);
    `CHK("multicast valid", 9'h100, vld)
    apb(1'b1, PFCI_CTRL_OFF, 32'h0000_5000);
    frame(PFCI_ETYPE, PFCI_OP_GLOBAL, 8'h00, 16'h0600);
    `CHK("unicast miss valid", 9'h000, vld)
    apb(1'b1, PFCI_STA_LO_OFF, 32'hc200_0001);
    apb(1'b1, PFCI_STA_HI_OFF, 32'h0000_0180);
    frame(PFCI_ETYPE, PFCI_OP_GLOBAL, 8'h00, 16'h0601);
    `CHK("unicast hit valid", 9'h100, vld)
    `CHK("unicast quanta", 16'h0601, quanta[8])
  endtask

  task automatic s_tx;
    tx_en <= 9'h155;
    repeat (3) @(posedge sys_clk);
    `CHK("tx gate", 9'h155, gate)
    rdc(PFCI_REQ_OFF, 32'h0155_0000, "tx gate reg");
  endtask

  initial begin
    rstn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    rx_frame = '0;
    tx_en = 9'h000;
    ack_delay = 3'h0;
    repeat (20) @(posedge sys_clk);
    rstn <= 1'b1;
    s_reset;
    s_disabled;
    s_global;
    s_prio;
    s_ctrl;
    s_checks;
    s_tx;
    complete_run;
  end

  // the sequence needs under two hundred cycles
  initial begin
    repeat (4000) @(posedge sys_clk);
    num_errors++;
    complete_run;
  end
endmodule

// >>> testbench/pfci_user_model.sv
// user logic model: acknowledges pause requests and applies flagged quanta
module pfci_user_model
  import pfci_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic [2:0] ack_delay,
  input wire logic [8:0] rx_flow_request,
  input wire logic [8:0] rx_flow_valid,
  input wire logic [8:0][15:0] rx_flow_quanta,
  output logic [8:0] rx_flow_acknowledge,
  output logic [8:0][15:0] applied
);
  logic [8:0][2:0] age;

  // delay sets how long a request waits: zero is prompt, six is slow
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      age <= '0;
      applied <= '0;
      rx_flow_acknowledge <= '0;
    end else begin
      for (int i = 0; i < 9; i++) begin
        if (rx_flow_valid[i]) begin
          applied[i] <= rx_flow_quanta[i];
        end
        age[i] <= (rx_flow_request[i] && !rx_flow_acknowledge[i]) ? age[i] + 3'h1 : 3'h0;
        rx_flow_acknowledge[i] <= rx_flow_request[i] && age[i] == ack_delay;
      end
    end
  end
endmodule
